// *** shared/tap_regs.vh ***
`ifndef TAP_REGS_VH
`define TAP_REGS_VH
// instruction codes
`define IR_WIDTH        3
`define IR_EXTERNAL     3'h0
`define IR_IDENTIFY     3'h1
`define IR_HIGHZ_SAMPLE 3'h2
`define IR_RESERVED_A   3'h3
`define IR_SAMPLE       3'h4
`define IR_PRIVATE      3'h5
`define IR_RESERVED_B   3'h6
`define IR_BYPASS       3'h7
`define IR_CAPTURE_VAL  2'h1
// identification code, value arbitrary
`define ID_CODE         32'h0000_0A5B
`define ID_WIDTH        32
// boundary scan geometry
`define BSR_IN_W        8
`define BSR_OUT_W       8
`define BSR_PAD_W       2
`define BSR_W           18
`define BSR_PAD_DEFAULT 2'h3
// reset by tms high
`define TMS_RESET_EDGES 3'h5
// synchroniser reset levels, matching the pins' idle high
`define TCK_SYNC_RESET  3'h7
`define PIN_SYNC_RESET  2'h3
// data register paths
`define DR_ID           2'h0
`define DR_BYP          2'h1
`define DR_BSR          2'h2
`define BYP_CAPTURE_VAL 1'h0
// tap states
`define ST_RESET    4'h0
`define ST_IDLE     4'h1
`define ST_SEL_DR   4'h2
`define ST_CAP_DR   4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR   4'h8
`define ST_SEL_IR   4'h9
`define ST_CAP_IR   4'ha
`define ST_SHIFT_IR 4'hb
`define ST_EXIT1_IR 4'hc
`define ST_PAUSE_IR 4'hd
`define ST_EXIT2_IR 4'he
`define ST_UPD_IR   4'hf
`endif

// *** core/sram_boundary_scan_tap.v ***
`timescale 1ns/10ps
`include "tap_regs.vh"
module sram_boundary_scan_tap (
  // system
  input  wire                  clk_sys,
  input  wire                  rst,
  // test port pins
  input  wire                  tck,
  input  wire                  tms,
  input  wire                  tdi,
  output reg                   tdo_o,
  output reg                   tdo_oe,
  // memory pins seen by the scan ring
  input  wire [`BSR_IN_W-1:0]  pin_in,
  input  wire [`BSR_OUT_W-1:0] func_out,
  input  wire                  func_out_en,
  // memory pin drivers
  output wire [`BSR_OUT_W-1:0] pad_out,
  output wire                  pad_out_en,
  // state view
  output reg  [`IR_WIDTH-1:0]  instr_active
);

  //////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detect
  reg [2:0] tck_s_q;
  reg [1:0] tms_s_q;
  reg [1:0] tdi_s_q;
  wire      tck_rise;
  wire      tck_fall;
  wire      tms_v;
  wire      tdi_v;

  // pins idle high, so every stage resets high and no false edge follows reset
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tck_s_q <= `TCK_SYNC_RESET;
    end else begin
      tck_s_q <= {tck_s_q[1:0], tck};
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tms_s_q <= `PIN_SYNC_RESET;
    end else begin
      tms_s_q <= {tms_s_q[0], tms};
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdi_s_q <= `PIN_SYNC_RESET;
    end else begin
      tdi_s_q <= {tdi_s_q[0], tdi};
    end
  end

  // only the second stage and the edge flop feed logic
  assign tck_rise = tck_s_q[1] & ~tck_s_q[2];
  assign tck_fall = ~tck_s_q[1] & tck_s_q[2];
  assign tms_v    = tms_s_q[1];
  assign tdi_v    = tdi_s_q[1];

  //////////////////////////////////////////////////////////////////////////
  // tap state machine
  reg [3:0] st_q;
  reg [3:0] st_d;

  function [3:0] next_state;
    input [3:0] s;
    input       m;
    begin
      case (s)
        `ST_RESET:    next_state = m ? `ST_RESET    : `ST_IDLE;
        `ST_IDLE:     next_state = m ? `ST_SEL_DR   : `ST_IDLE;
        `ST_SEL_DR:   next_state = m ? `ST_SEL_IR   : `ST_CAP_DR;
        `ST_CAP_DR:   next_state = m ? `ST_EXIT1_DR : `ST_SHIFT_DR;
        `ST_SHIFT_DR: next_state = m ? `ST_EXIT1_DR : `ST_SHIFT_DR;
        `ST_EXIT1_DR: next_state = m ? `ST_UPD_DR   : `ST_PAUSE_DR;
        `ST_PAUSE_DR: next_state = m ? `ST_EXIT2_DR : `ST_PAUSE_DR;
        `ST_EXIT2_DR: next_state = m ? `ST_UPD_DR   : `ST_SHIFT_DR;
        `ST_UPD_DR:   next_state = m ? `ST_SEL_DR   : `ST_IDLE;
        `ST_SEL_IR:   next_state = m ? `ST_RESET    : `ST_CAP_IR;
        `ST_CAP_IR:   next_state = m ? `ST_EXIT1_IR : `ST_SHIFT_IR;
        `ST_SHIFT_IR: next_state = m ? `ST_EXIT1_IR : `ST_SHIFT_IR;
        `ST_EXIT1_IR: next_state = m ? `ST_UPD_IR   : `ST_PAUSE_IR;
        `ST_PAUSE_IR: next_state = m ? `ST_EXIT2_IR : `ST_PAUSE_IR;
        `ST_EXIT2_IR: next_state = m ? `ST_UPD_IR   : `ST_SHIFT_IR;
        `ST_UPD_IR:   next_state = m ? `ST_SEL_DR   : `ST_IDLE;
        default:      next_state = `ST_RESET;
      endcase
    end
  endfunction

  // consecutive tms-high rises; the fifth forces the reset state on its own
  reg [2:0] tms_cnt_q;
  wire      tms_reset_hit = tms_v & (tms_cnt_q == `TMS_RESET_EDGES - 3'h1);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tms_cnt_q <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_v) begin
        tms_cnt_q <= 3'h0;
      end else if (!tms_reset_hit) begin
        tms_cnt_q <= tms_cnt_q + 3'h1;
      end
    end
  end

  always @* begin
    st_d = st_q;
    if (tck_rise) begin
      st_d = tms_reset_hit ? `ST_RESET : next_state(st_q, tms_v);
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= `ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-state strobes, each one clk_sys cycle long, and the in_shift level that lasts the whole shift state
  wire cap_ir_stb;
  wire shift_ir_stb;
  wire upd_ir_fall;
  wire cap_dr_stb;
  wire shift_dr_stb;
  wire upd_dr_fall;
  wire in_shift;

  assign cap_ir_stb   = tck_rise & (st_q == `ST_CAP_IR);
  assign shift_ir_stb = tck_rise & (st_q == `ST_SHIFT_IR);
  assign upd_ir_fall  = tck_fall & (st_q == `ST_UPD_IR);
  assign cap_dr_stb   = tck_rise & (st_q == `ST_CAP_DR);
  assign shift_dr_stb = tck_rise & (st_q == `ST_SHIFT_DR);
  assign upd_dr_fall  = tck_fall & (st_q == `ST_UPD_DR);
  assign in_shift     = (st_q == `ST_SHIFT_IR) | (st_q == `ST_SHIFT_DR);

  //////////////////////////////////////////////////////////////////////////
  // instruction decode
  reg  [`IR_WIDTH-1:0] ir_shift_q;
  wire [1:0]           path_sel;
  wire                 sel_id;
  wire                 sel_ext;
  wire                 sel_hiz;
  wire                 sel_bsr;
  wire                 sel_byp;

  // scan path of a code; reserved and private codes fall to bypass
  function [1:0] dr_path;
    input [`IR_WIDTH-1:0] code;
    begin
      case (code)
        `IR_EXTERNAL:     dr_path = `DR_BSR;
        `IR_IDENTIFY:     dr_path = `DR_ID;
        `IR_HIGHZ_SAMPLE: dr_path = `DR_BSR;
        `IR_RESERVED_A:   dr_path = `DR_BYP;
        `IR_SAMPLE:       dr_path = `DR_BSR;
        `IR_PRIVATE:      dr_path = `DR_BYP;
        `IR_RESERVED_B:   dr_path = `DR_BYP;
        `IR_BYPASS:       dr_path = `DR_BYP;
        default:          dr_path = `DR_BYP;
      endcase
    end
  endfunction

  assign path_sel = dr_path(instr_active);
  assign sel_id   = (path_sel == `DR_ID);
  assign sel_ext  = (instr_active == `IR_EXTERNAL);
  assign sel_hiz  = (instr_active == `IR_HIGHZ_SAMPLE);
  assign sel_bsr  = (path_sel == `DR_BSR);
  assign sel_byp  = (path_sel == `DR_BYP);

  //////////////////////////////////////////////////////////////////////////
  // instruction register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ir_shift_q <= `IR_IDENTIFY;
    end else if (cap_ir_stb) begin
      ir_shift_q <= {1'h0, `IR_CAPTURE_VAL};
    end else if (shift_ir_stb) begin
      ir_shift_q <= {tdi_v, ir_shift_q[`IR_WIDTH-1:1]};
    end
  end

  // active code: identify whenever in reset state, new code at update-ir fall
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      instr_active <= `IR_IDENTIFY;
    end else if (st_q == `ST_RESET) begin
      instr_active <= `IR_IDENTIFY;
    end else if (upd_ir_fall) begin
      instr_active <= ir_shift_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data registers
  reg [`ID_WIDTH-1:0] id_q;
  reg                 byp_q;
  reg [`BSR_W-1:0]    bsr_q;
  reg [`BSR_OUT_W-1:0] bsr_upd_q;
  wire [`BSR_W-1:0]   bsr_cap = {`BSR_PAD_DEFAULT, func_out, pin_in};

  // identification register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      id_q <= `ID_CODE;
    end else if (cap_dr_stb && sel_id) begin
      id_q <= `ID_CODE;
    end else if (shift_dr_stb && sel_id) begin
      id_q <= {tdi_v, id_q[`ID_WIDTH-1:1]};
    end
  end

  // bypass stage
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      byp_q <= `BYP_CAPTURE_VAL;
    end else if (cap_dr_stb && sel_byp) begin
      byp_q <= `BYP_CAPTURE_VAL;
    end else if (shift_dr_stb && sel_byp) begin
      byp_q <= tdi_v;
    end
  end

  // boundary scan register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bsr_q <= {`BSR_W{1'h0}};
    end else if (cap_dr_stb && sel_bsr) begin
      bsr_q <= bsr_cap;
    end else if (shift_dr_stb && sel_bsr) begin
      bsr_q <= {tdi_v, bsr_q[`BSR_W-1:1]};
    end
  end

  // output latch for scan-driven pins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bsr_upd_q <= {`BSR_OUT_W{1'h0}};
    end else if (upd_ir_fall || upd_dr_fall) begin
      bsr_upd_q <= bsr_q[`BSR_IN_W+`BSR_OUT_W-1:`BSR_IN_W];
    end
  end

  // functional inputs pass straight through; only outputs are steered
  assign pad_out    = sel_ext ? bsr_upd_q : func_out;
  assign pad_out_en = sel_hiz ? 1'b0 : (sel_ext ? 1'b1 : func_out_en);

  //////////////////////////////////////////////////////////////////////////
  // tdo, driven on falling edge
  reg tdo_bit;
  always @* begin
    tdo_bit = byp_q;
    if (st_q == `ST_SHIFT_IR) begin
      tdo_bit = ir_shift_q[0];
    end else begin
      case (path_sel)
        `DR_ID:  tdo_bit = id_q[0];
        `DR_BSR: tdo_bit = bsr_q[0];
        default: tdo_bit = byp_q;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdo_o <= 1'h0;
    end else if (tck_fall) begin
      tdo_o <= tdo_bit;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdo_oe <= 1'h0;
    end else if (tck_fall) begin
      tdo_oe <= in_shift;
    end
  end

endmodule

// *** tb/tap_chk_properties.sv ***
`timescale 1ns/10ps
module tap_chk (
  // system
  input wire       clk_sys,
  input wire       rst,
  // test port
  input wire       tck,
  input wire       tdo_o,
  input wire       tdo_oe,
  // memory pins
  input wire [7:0] func_out,
  input wire       func_out_en,
  input wire [7:0] pad_out,
  input wire       pad_out_en,
  input wire [2:0] instr_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // test clock seen low on the two previous samples
  sequence s_tck_low;
    !$past(tck, 2) ##0 !$past(tck, 1);
  endsequence
  property p_ext; instr_active == 3'h0 |-> pad_out_en; endproperty
  a_ext: assert property (p_ext) else $error("enable low in ext test");
  property p_hiz; instr_active == 3'h2 |-> !pad_out_en; endproperty
  a_hiz: assert property (p_hiz) else $error("driver on in hiz");
  property p_fdat; instr_active != 3'h0 |-> pad_out == func_out; endproperty
  a_fdat: assert property (p_fdat) else $error("pad data not func");
  property p_fen; instr_active != 3'h0 && instr_active != 3'h2 |-> pad_out_en == func_out_en; endproperty
  a_fen: assert property (p_fen) else $error("pad enable not func");
  property p_rid; $fell(rst) |-> (instr_active == 3'h1) [*3]; endproperty
  a_rid: assert property (p_rid) else $error("no id code at reset");
  property p_hold; tdo_oe |-> $stable(instr_active); endproperty
  a_hold: assert property (p_hold) else $error("instr changed in shift");
  property p_tdo; $changed(tdo_o) |-> s_tck_low; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo moved off fall");
  property p_oe; $changed(tdo_oe) |-> s_tck_low; endproperty
  a_oe: assert property (p_oe) else $error("tdo enable moved off fall");
endmodule
bind sram_boundary_scan_tap tap_chk chk (.clk_sys, .rst, .tck, .tdo_o, .tdo_oe, .func_out,
  .func_out_en, .pad_out, .pad_out_en, .instr_active);

// *** tb/test_ctl.sv ***
`timescale 1ns/10ps
module test_ctl (
  // system
  input  wire  clk_sys,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input  wire  tdo_o,
  input  wire  tdo_oe
);
  logic tdo_s;
  logic oe_s;
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock: fall, 4 sys clocks low, rise, 4 high
  task cyc(input logic t, input logic d);
    @(posedge clk_sys);
    tdo_s = tdo_o;
    oe_s = tdo_oe;
    tck <= 1'b0;
    tms <= t;
    tdi <= d;
    repeat (4) @(posedge clk_sys);
    tck <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout, output logic ok);
    cyc(1'b1, 1'b0);
    if (ir)
      cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b0);
    cyc(1'b0, 1'b0);
    dout = 32'h0000_0000;
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i]);
      if (i > 0) begin
        dout[i-1] = tdo_s;
        ok &= oe_s;
      end else begin
        ok &= !oe_s;
      end
    end
    cyc(1'b1, 1'b0);
    dout[n-1] = tdo_s;
    ok &= oe_s;
    cyc(1'b0, 1'b0);
    ok &= !oe_s;
  endtask
endmodule

// *** tb/tb_sram_boundary_scan_tap.sv ***
`timescale 1ns/10ps
`include "tap_regs.vh"
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
module tb_sram_boundary_scan_tap;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] pin_in = 8'h5a;
  logic [7:0] func_out = 8'hc3;
  logic       func_out_en = 1'b1;
  wire        tck, tms, tdi, tdo_o, tdo_oe, pad_out_en;
  wire [7:0]  pad_out;
  wire [2:0]  instr_active;
  logic [31:0] d;
  logic       ok;
  logic [2:0] codes [2] = '{`IR_RESERVED_A, `IR_RESERVED_B};
  int         errors = 0;
  int         num_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  sram_boundary_scan_tap dut (.clk_sys, .rst, .tck, .tms, .tdi, .tdo_o, .tdo_oe, .pin_in,
    .func_out, .func_out_en, .pad_out, .pad_out_en, .instr_active);
  test_ctl ctl (.clk_sys, .tck, .tms, .tdi, .tdo_o, .tdo_oe);
  task stop_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task ir(input logic [2:0] c);
    ctl.scan(1'b1, 3, {29'h0, c}, d, ok);
    `CHK("ir capture", 2'h1, d[1:0])
    `CHK("instr", c, instr_active)
  endtask
  initial begin
    #400_000;
    errors++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK("instr", `IR_IDENTIFY, instr_active)
    ctl.cyc(1'b0, 1'b0);
    ctl.scan(1'b0, 32, 32'h0, d, ok);
    `CHK("id", `ID_CODE, d)
    `CHK("tdo enable", 1'b1, ok)
    func_out_en <= 1'b0;
    // private code 101 is never issued
    foreach (codes[k]) begin
      ir(codes[k]);
      ctl.scan(1'b0, 4, 32'hd, d, ok);
      `CHK("bypass", 3'h5, d[3:1])
    end
    ir(`IR_BYPASS);
    ir(`IR_SAMPLE);
    ctl.scan(1'b0, 18, 32'h1_3c96, d, ok);
    `CHK("sample", {14'h0, 2'h3, 8'hc3, 8'h5a}, d)
    ir(`IR_EXTERNAL);
    `CHK("ext pad", 8'h3c, pad_out)
    func_out <= 8'h81;
    @(posedge clk_sys);
    `CHK("ext hold", 8'h3c, pad_out)
    ctl.scan(1'b0, 18, 32'h0, d, ok);
    `CHK("ext capture", {14'h0, 2'h3, 8'h81, 8'h5a}, d)
    `CHK("ext update", 8'h00, pad_out)
    ir(`IR_HIGHZ_SAMPLE);
    `CHK("hiz enable", 1'b0, pad_out_en)
    pin_in <= 8'h0f;
    ctl.scan(1'b0, 18, 32'h0, d, ok);
    `CHK("hiz capture", {14'h0, 2'h3, 8'h81, 8'h0f}, d)
    repeat (5) ctl.cyc(1'b1, 1'b0);
    ctl.cyc(1'b0, 1'b0);
    `CHK("tms reset", `IR_IDENTIFY, instr_active)
    stop_test;
  end
endmodule
